// ---- hdl/crm_routing.sv ----
// Functional notes
// RULE_01: operand a picks source, destination, bus, pc
// RULE_02: operand b picks source, bus, two constant selectors
// RULE_03: step constants: one, two, source, destination
// RULE_04: vectors: trap, start, loop offset, branch offset
// RULE_05: shifter passes, swaps, shifts or substitutes pc
// RULE_06: source register input: general port or shifter
// RULE_07: destination register input: general port or shifter
// RULE_08: bus register input: shifter, buffered bus, fast, internal
// RULE_09: transfer address from pc, source or destination
// RULE_10: exponent value only for display, never addressed
// RULE_11: system bus data through selector; others from bus register
// RULE_12: implicit transfers: no address, internal bus, load strobe
// RULE_13: gate only chosen source, load only intended targets
// RULE_14: storage by load strobes, selection by multiplexers
// RULE_15: data display four words; address display from selector
// RULE_16: display choice follows sampled console switches
// RULE_17: pc write path bypasses the shifter
// RULE_18: offsets shifted and sign-extended from bus register
// RULE_19: controls held stable across the machine cycle
`timescale 1ns/1ps
module crm_routing import crm_pkg::*; #(
  parameter int W = WORD_W,
  parameter int NDEV = DEV_N,
  parameter logic [WORD_W-1:0] START_VEC = START_VEC_RST
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // microword and cycle timing
  input wire logic cycle_start,
  input wire logic cycle_end,
  input wire uword_type uword,
  // storage and alu values
  input wire logic [W-1:0] sr_val,
  input wire logic [W-1:0] dr_val,
  input wire logic [W-1:0] br_val,
  input wire logic [W-1:0] pc_val,
  input wire logic [W-1:0] gen_src_rd,
  input wire logic [W-1:0] gen_dst_rd,
  input wire logic [W-1:0] trap_vec,
  input wire logic [W-1:0] src_const,
  input wire logic [W-1:0] dst_const,
  input wire logic [W-1:0] alu_res,
  input wire logic [W-1:0] exp_val,
  // inbound buses
  input wire logic t3,
  input wire logic [W-1:0] sys_bus_rd,
  input wire logic [W-1:0] fast_bus_rd,
  input wire logic [W-1:0] ibus_rd,
  input wire logic [W-1:0] aux_rd,
  // transfer requests
  input wire logic xfer_req,
  input wire logic impl_req,
  input wire logic impl_out,
  input wire logic [$clog2(NDEV)-1:0] impl_dev,
  // console switches
  input wire logic [1:0] sw_disp_sel,
  input wire logic sw_addr_hold,
  // alu and register feeds
  output logic [W-1:0] alu_a,
  output logic [W-1:0] alu_b,
  output logic [W-1:0] shf_out,
  output logic [W-1:0] pc_wr_data,
  output logic [W-1:0] sr_in,
  output logic [W-1:0] dr_in,
  output logic [W-1:0] br_in,
  output logic sr_load,
  output logic dr_load,
  output logic br_load,
  // outbound transfer
  output logic [W-1:0] xfer_addr,
  output logic xfer_addr_vld,
  output logic [W-1:0] sys_wr_data,
  output logic [W-1:0] fast_wr_data,
  output logic [W-1:0] ibus_wr_data,
  output logic ibus_drive,
  output logic [NDEV-1:0] dev_load,
  output logic [NDEV-1:0] dev_gate,
  // console lights
  output logic [W-1:0] disp_data,
  output logic [W-1:0] disp_addr
);
  uword_type uword_q;
  logic [W-1:0] sys_buf_q;
  disp_sel_type sw_disp_q;
  logic sw_hold_q;
  logic [W-1:0] disp_data_q;
  logic [W-1:0] disp_addr_q;
  logic [W-1:0] ba_mux;
  logic [NDEV-1:0] dev_hot;
  logic impl_in;

  crm_sel_if #(.W(W)) sel ();

  assign sel.br = br_val;
  assign sel.pc = pc_val;
  assign sel.trap_vec = trap_vec;
  assign sel.start_vec = START_VEC;
  assign sel.src_const = src_const;
  assign sel.dst_const = dst_const;
  assign sel.alu_res = alu_res;
  assign sel.k0_sel = uword_q.k0_sel;
  assign sel.k1_sel = uword_q.k1_sel;
  assign sel.shf_sel = uword_q.shf_sel;

  crm_const_sel #(.W(W)) u_const (
    .s(sel)
  );

  crm_shift_swap #(.W(W)) u_shift (
    .s(sel)
  );

  // microword held for the whole cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      uword_q <= UWORD_RST;
    end else if (ce && cycle_start) begin
      uword_q <= uword; // RULE_19
    end
  end

  always_comb begin
    unique case (uword_q.a_sel)
      A_SRC: alu_a = sr_val; // RULE_01
      A_DST: alu_a = dr_val; // RULE_01
      A_BUS: alu_a = br_val; // RULE_01
      A_PC: alu_a = pc_val; // RULE_01
    endcase
  end

  always_comb begin
    unique case (uword_q.b_sel)
      B_SRC: alu_b = sr_val; // RULE_02
      B_BUS: alu_b = br_val; // RULE_02
      B_K0: alu_b = sel.k0_out; // RULE_02
      B_K1: alu_b = sel.k1_out; // RULE_02
    endcase
  end

  assign shf_out = sel.shf_out; // RULE_05
  assign pc_wr_data = alu_res; // RULE_17

  assign sr_in = uword_q.sr_from_shf ? sel.shf_out : gen_src_rd; // RULE_06
  assign dr_in = uword_q.dr_from_shf ? sel.shf_out : gen_dst_rd; // RULE_07

  // system bus word caught at every t3 while ce is high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_buf_q <= '0;
    end else if (ce && t3) begin
      sys_buf_q <= sys_bus_rd; // RULE_08
    end
  end

  always_comb begin
    unique case (uword_q.br_in_sel)
      BRI_SHF: br_in = sel.shf_out; // RULE_08
      BRI_SYS: br_in = sys_buf_q; // RULE_08
      BRI_FAST: br_in = fast_bus_rd; // RULE_08
      BRI_IBUS: br_in = ibus_rd; // RULE_08
    endcase
  end

  always_comb begin
    unique case (uword_q.ba_sel)
      BA_PC: ba_mux = pc_val; // RULE_09
      BA_SRC: ba_mux = sr_val; // RULE_09
      BA_DST: ba_mux = dr_val; // RULE_09
      BA_EXP: ba_mux = exp_val; // RULE_10
    endcase
  end

  assign xfer_addr = ba_mux;
  // exponent and implicit cycles never present an address
  assign xfer_addr_vld = xfer_req && !impl_req && uword_q.ba_sel != BA_EXP; // RULE_10 RULE_12

  assign sys_wr_data = uword_q.dmx_aux ? aux_rd : br_val; // RULE_11
  assign fast_wr_data = br_val; // RULE_11
  assign ibus_wr_data = br_val; // RULE_11 RULE_12

  // internal bus: one source gated, one target loaded
  always_comb begin
    dev_hot = '0;
    dev_hot[impl_dev] = 1'b1;
  end

  assign impl_in = impl_req && !impl_out;
  assign ibus_drive = impl_req && impl_out; // RULE_13
  assign dev_gate = impl_in ? dev_hot : '0; // RULE_13
  assign dev_load = (ibus_drive && ce && cycle_end) ? dev_hot : '0; // RULE_12 RULE_13

  assign sr_load = ce && cycle_end && uword_q.ld_sr; // RULE_14
  assign dr_load = ce && cycle_end && uword_q.ld_dr; // RULE_14
  // inbound implicit word lands only in the bus register
  assign br_load = ce && cycle_end && (uword_q.ld_br || impl_in); // RULE_12 RULE_14

  // console switches sampled before use
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_disp_q <= DISP_SHF;
      sw_hold_q <= 1'b0;
    end else if (ce) begin
      sw_disp_q <= disp_sel_type'(sw_disp_sel); // RULE_16
      sw_hold_q <= sw_addr_hold; // RULE_16
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_data_q <= '0;
    end else if (ce) begin
      unique case (sw_disp_q)
        DISP_SHF: disp_data_q <= sel.shf_out; // RULE_15
        DISP_BUS: disp_data_q <= br_val; // RULE_15
        DISP_SRC: disp_data_q <= sr_val; // RULE_15
        DISP_DST: disp_data_q <= dr_val; // RULE_15
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_addr_q <= '0;
    end else if (ce && !sw_hold_q) begin
      disp_addr_q <= ba_mux; // RULE_15 RULE_16
    end
  end

  assign disp_data = disp_data_q;
  assign disp_addr = disp_addr_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_opa_pc_path: assert property ( // RULE_01
    uword_q.a_sel == A_PC |-> alu_a == pc_val
  ) else $error("operand a not pc");

  a_opb_const_two: assert property ( // RULE_03
    uword_q.b_sel == B_K0 && uword_q.k0_sel == K0_TWO |-> alu_b == CONST_TWO
  ) else $error("operand b not two");

  a_branch_offset: assert property ( // RULE_18
    uword_q.b_sel == B_K1 && uword_q.k1_sel == K1_BRANCH
      |-> alu_b[0] == 1'b0 && alu_b[W-1] == br_val[BR_OFS_MSB]
      && alu_b[BR_OFS_MSB+1] == br_val[BR_OFS_MSB]
  ) else $error("branch offset wrong");

  a_pc_bypass: assert property ( // RULE_17
    uword_q.shf_sel != SHF_PASS |-> pc_wr_data == alu_res
  ) else $error("pc path went through shifter");

  a_t3_capture: assert property ( // RULE_08
    ce && t3 && !(ce && cycle_start) && uword_q.br_in_sel == BRI_SYS
      |=> br_in == $past(sys_bus_rd)
  ) else $error("bus buffer not caught at t3");

  a_exp_no_addr: assert property ( // RULE_10
    uword_q.ba_sel == BA_EXP |-> !xfer_addr_vld
  ) else $error("exponent used as address");

  a_impl_quiet: assert property ( // RULE_12
    impl_req |-> !xfer_addr_vld && (dev_load == '0 || ibus_drive)
  ) else $error("implicit transfer sent address");

  a_load_onehot: assert property ( // RULE_13
    $onehot0(dev_load) && $onehot0(dev_gate) && !(ibus_drive && dev_gate != '0)
  ) else $error("more than one internal bus party");

  a_uword_stable: assert property ( // RULE_19
    !(ce && cycle_start) |=> $stable(uword_q)
  ) else $error("microword moved mid cycle");

  a_disp_follow: assert property ( // RULE_16
    ce && sw_disp_q == DISP_BUS |=> disp_data == $past(br_val)
  ) else $error("display ignores switches");

  a_sys_data_path: assert property ( // RULE_11
    !uword_q.dmx_aux |-> sys_wr_data == br_val && fast_wr_data == br_val
  ) else $error("outbound data wrong");

  a_ce_freeze: assert property ( // RULE_19
    !ce |=> $stable(uword_q) && $stable(sys_buf_q) && $stable(disp_data) && $stable(disp_addr)
  ) else $error("state moved with enable low");

  a_load_at_end: assert property ( // RULE_14
    sr_load || dr_load || br_load || dev_load != '0 |-> ce && cycle_end
  ) else $error("load strobe outside cycle end");

  a_addr_lights: assert property ( // RULE_15
    ce && !sw_hold_q |=> disp_addr == $past(xfer_addr)
  ) else $error("address lights not following");

  a_gate_inbound: assert property ( // RULE_13
    dev_gate != '0 |-> impl_req && !impl_out && !ibus_drive
  ) else $error("device gated outside inbound transfer");

  c_branch_add: cover property (uword_q.b_sel == B_K1 && uword_q.k1_sel == K1_BRANCH);
  c_impl_out: cover property (ibus_drive && dev_load != '0);
  c_impl_in: cover property (impl_in && br_load);
  c_sys_read: cover property (ce && t3 ##1 uword_q.br_in_sel == BRI_SYS && br_load);
endmodule // crm_routing

// ---- hdl/crm_pkg.sv ----
package crm_pkg;
  localparam int WORD_W = 16;
  localparam int DEV_N = 4;
  localparam logic [WORD_W-1:0] CONST_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] CONST_TWO = 16'h0002;
  localparam logic [WORD_W-1:0] START_VEC_RST = 16'h0000;
  localparam int BR_OFS_MSB = 7;
  localparam int LOOP_OFS_MSB = 5;

  typedef enum logic [1:0] {A_SRC = 2'h0, A_DST = 2'h1, A_BUS = 2'h2, A_PC = 2'h3} a_sel_type;
  typedef enum logic [1:0] {B_SRC = 2'h0, B_BUS = 2'h1, B_K0 = 2'h2, B_K1 = 2'h3} b_sel_type;
  typedef enum logic [1:0] {
    K0_ONE = 2'h0, K0_TWO = 2'h1, K0_SRC = 2'h2, K0_DST = 2'h3
  } k0_sel_type;
  typedef enum logic [1:0] {
    K1_TRAP = 2'h0, K1_START = 2'h1, K1_LOOP = 2'h2, K1_BRANCH = 2'h3
  } k1_sel_type;
  typedef enum logic [1:0] {
    SHF_PASS = 2'h0, SHF_SWAP = 2'h1, SHF_RIGHT = 2'h2, SHF_PC = 2'h3
  } shf_sel_type;
  typedef enum logic [1:0] {
    BRI_SHF = 2'h0, BRI_SYS = 2'h1, BRI_FAST = 2'h2, BRI_IBUS = 2'h3
  } br_in_sel_type;
  typedef enum logic [1:0] {BA_PC = 2'h0, BA_SRC = 2'h1, BA_DST = 2'h2, BA_EXP = 2'h3} ba_sel_type;
  typedef enum logic [1:0] {
    DISP_SHF = 2'h0, DISP_BUS = 2'h1, DISP_SRC = 2'h2, DISP_DST = 2'h3
  } disp_sel_type;

  typedef struct packed {
    a_sel_type a_sel;
    b_sel_type b_sel;
    k0_sel_type k0_sel;
    k1_sel_type k1_sel;
    shf_sel_type shf_sel;
    logic sr_from_shf;
    logic dr_from_shf;
    br_in_sel_type br_in_sel;
    ba_sel_type ba_sel;
    logic dmx_aux;
    logic ld_sr;
    logic ld_dr;
    logic ld_br;
  } uword_type;
  localparam int UWORD_W = 20;
  localparam uword_type UWORD_RST = 20'h00000;
endpackage

// ---- hdl/crm_sel_if.sv ----
`timescale 1ns/1ps
interface crm_sel_if import crm_pkg::*; #(parameter int W = WORD_W) ();
  logic [W-1:0] br;
  logic [W-1:0] pc;
  logic [W-1:0] trap_vec;
  logic [W-1:0] start_vec;
  logic [W-1:0] src_const;
  logic [W-1:0] dst_const;
  logic [W-1:0] alu_res;
  logic [W-1:0] k0_out;
  logic [W-1:0] k1_out;
  logic [W-1:0] shf_out;
  k0_sel_type k0_sel;
  k1_sel_type k1_sel;
  shf_sel_type shf_sel;
  modport core(output br, pc, trap_vec, start_vec, src_const, dst_const, alu_res,
    output k0_sel, k1_sel, shf_sel, input k0_out, k1_out, shf_out);
  modport konst(input br, trap_vec, start_vec, src_const, dst_const, k0_sel, k1_sel,
    output k0_out, k1_out);
  modport shifter(input alu_res, pc, shf_sel, output shf_out);
endinterface

// ---- hdl/crm_const_sel.sv ----
`timescale 1ns/1ps
module crm_const_sel import crm_pkg::*; #(
  parameter int W = WORD_W
) (
  // selector bundle
  crm_sel_if.konst s
);
  // offset: bits up to msb moved up one place, top bit copied upward
  function automatic logic [W-1:0] shift_sext(input logic [W-1:0] v, input int msb);
    logic [W-1:0] r;
    r = '0;
    for (int i = 1; i < W; i++) begin
      r[i] = (i - 1 <= msb) ? v[i-1] : v[msb];
    end
    return r;
  endfunction

  always_comb begin
    unique case (s.k0_sel)
      K0_ONE: s.k0_out = CONST_ONE; // RULE_03
      K0_TWO: s.k0_out = CONST_TWO; // RULE_03
      K0_SRC: s.k0_out = s.src_const; // RULE_03
      K0_DST: s.k0_out = s.dst_const; // RULE_03
    endcase
  end

  always_comb begin
    unique case (s.k1_sel)
      K1_TRAP: s.k1_out = s.trap_vec; // RULE_04
      K1_START: s.k1_out = s.start_vec; // RULE_04
      K1_LOOP: s.k1_out = shift_sext(s.br, LOOP_OFS_MSB); // RULE_18
      K1_BRANCH: s.k1_out = shift_sext(s.br, BR_OFS_MSB); // RULE_18
    endcase
  end
endmodule // crm_const_sel

// ---- hdl/crm_shift_swap.sv ----
`timescale 1ns/1ps
module crm_shift_swap import crm_pkg::*; #(
  parameter int W = WORD_W
) (
  // selector bundle
  crm_sel_if.shifter s
);
  always_comb begin
    unique case (s.shf_sel)
      SHF_PASS: s.shf_out = s.alu_res; // RULE_05
      SHF_SWAP: s.shf_out = {s.alu_res[W/2-1:0], s.alu_res[W-1:W/2]}; // RULE_05
      SHF_RIGHT: s.shf_out = {s.alu_res[W-1], s.alu_res[W-1:1]}; // RULE_05
      SHF_PC: s.shf_out = s.pc; // RULE_05
    endcase
  end
endmodule // crm_shift_swap

// ---- verification/crm_store_model.sv ----
`timescale 1ns/1ps
module crm_store_model import crm_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register feeds and strobes
  input wire logic [WORD_W-1:0] sr_in,
  input wire logic [WORD_W-1:0] dr_in,
  input wire logic [WORD_W-1:0] br_in,
  input wire logic sr_load,
  input wire logic dr_load,
  input wire logic br_load,
  // alu operands
  input wire logic [WORD_W-1:0] alu_a,
  input wire logic [WORD_W-1:0] alu_b,
  // stored values and result
  output logic [WORD_W-1:0] sr_q,
  output logic [WORD_W-1:0] dr_q,
  output logic [WORD_W-1:0] br_q,
  output logic [WORD_W-1:0] alu_res
);
  // only a strobed register captures
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= 16'h0000;
      dr_q <= 16'h0000;
      br_q <= 16'h0000;
    end else begin
      if (sr_load) sr_q <= sr_in;
      if (dr_load) dr_q <= dr_in;
      if (br_load) br_q <= br_in;
    end
  end
  // alu stands in as a plain adder
  assign alu_res = alu_a + alu_b;
endmodule // crm_store_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import crm_pkg::*; ();
  logic sys_clk, rst_b, ce, cycle_start, cycle_end, t3, xfer_req, impl_req, impl_out;
  logic sw_addr_hold, sr_load, dr_load, br_load, xfer_addr_vld, ibus_drive;
  logic [1:0] impl_dev, sw_disp_sel;
  logic [3:0] dev_load, dev_gate;
  logic [15:0] sr_val, dr_val, br_val, pc_val, gen_src_rd, gen_dst_rd, trap_vec, src_const;
  logic [15:0] dst_const, alu_res, exp_val, sys_bus_rd, fast_bus_rd, ibus_rd, aux_rd, alu_a;
  logic [15:0] alu_b, shf_out, pc_wr_data, sr_in, dr_in, br_in, xfer_addr, sys_wr_data;
  logic [15:0] fast_wr_data, ibus_wr_data, disp_data, disp_addr;
  uword_type uword, w;
  int bad_count, total_checks;

  crm_routing i_dut (.sys_clk, .rst_b, .ce, .cycle_start, .cycle_end, .uword, .sr_val,
    .dr_val, .br_val, .pc_val, .gen_src_rd, .gen_dst_rd, .trap_vec, .src_const, .dst_const,
    .alu_res, .exp_val, .t3, .sys_bus_rd, .fast_bus_rd, .ibus_rd, .aux_rd, .xfer_req,
    .impl_req, .impl_out, .impl_dev, .sw_disp_sel, .sw_addr_hold, .alu_a, .alu_b, .shf_out,
    .pc_wr_data, .sr_in, .dr_in, .br_in, .sr_load, .dr_load, .br_load, .xfer_addr,
    .xfer_addr_vld, .sys_wr_data, .fast_wr_data, .ibus_wr_data, .ibus_drive, .dev_load,
    .dev_gate, .disp_data, .disp_addr);
  crm_store_model i_store (.sys_clk, .rst_b, .sr_in, .dr_in, .br_in, .sr_load, .dr_load,
    .br_load, .alu_a, .alu_b, .sr_q(sr_val), .dr_q(dr_val), .br_q(br_val), .alu_res);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // start a machine cycle, return inside its last clock
  task automatic mcycle(input uword_type u);
    @(negedge sys_clk);
    cycle_end = 1'b0;
    uword = u;
    cycle_start = 1'b1;
    @(negedge sys_clk);
    cycle_start = 1'b0;
    cycle_end = 1'b1;
    #1;
  endtask

  task automatic load_regs(input logic [15:0] s, input logic [15:0] d, input logic [15:0] b);
    gen_src_rd = s;
    gen_dst_rd = d;
    fast_bus_rd = b;
    w = UWORD_RST;
    w.ld_sr = 1'b1;
    w.ld_dr = 1'b1;
    w.ld_br = 1'b1;
    w.br_in_sel = BRI_FAST;
    mcycle(w);
    chk(sr_in, s);
    chk(dr_in, d);
    chk(br_in, b);
    chk({13'h0, sr_load, dr_load, br_load}, 16'h0007);
    mcycle(UWORD_RST);
    chk({13'h0, sr_load, dr_load, br_load}, 16'h0000);
  endtask

  task automatic sc_operands;
    logic [15:0] ea [4];
    logic [15:0] eb [12];
    load_regs(16'h1234, 16'h5678, 16'h00a5);
    pc_val = 16'h0246;
    ea = '{16'h1234, 16'h5678, 16'h00a5, 16'h0246};
    eb = '{16'h1234, 16'h00a5, src_const, 16'hff4a, CONST_ONE, CONST_TWO, src_const, dst_const,
      trap_vec, START_VEC_RST, 16'hffca, 16'hff4a};
    for (int i = 0; i < 12; i++) begin
      w = UWORD_RST;
      w.a_sel = a_sel_type'(i % 4);
      w.b_sel = (i < 4) ? b_sel_type'(i) : ((i < 8) ? B_K0 : B_K1);
      w.k0_sel = k0_sel_type'(i % 4);
      w.k1_sel = k1_sel_type'(i % 4);
      mcycle(w);
      chk(alu_a, ea[i%4]);
      chk(alu_b, eb[i]);
    end
  endtask

  task automatic sc_shifter;
    logic [15:0] es [4];
    load_regs(16'hc1a4, 16'h0000, 16'h0000);
    es = '{16'h8348, 16'h4883, 16'hc1a4, pc_val};
    for (int i = 0; i < 4; i++) begin
      w = UWORD_RST;
      w.shf_sel = shf_sel_type'(i);
      w.sr_from_shf = 1'b1;
      w.dr_from_shf = 1'b1;
      mcycle(w);
      chk(shf_out, es[i]);
      chk(pc_wr_data, 16'h8348);
      chk(sr_in, es[i]);
      chk(dr_in, es[i]);
    end
  endtask

  task automatic sc_transfer;
    logic [15:0] ex [4];
    load_regs(16'h1000, 16'h2000, 16'h3c3c);
    pc_val = 16'h3000;
    exp_val = 16'h4000;
    aux_rd = 16'h5a5a;
    xfer_req = 1'b1;
    ex = '{16'h3000, 16'h1000, 16'h2000, 16'h4000};
    for (int i = 0; i < 4; i++) begin
      w = UWORD_RST;
      w.ba_sel = ba_sel_type'(i);
      w.dmx_aux = i[0];
      mcycle(w);
      chk(xfer_addr, ex[i]);
      chk({15'h0, xfer_addr_vld}, (i < 3) ? 16'h0001 : 16'h0000);
      chk(sys_wr_data, i[0] ? 16'h5a5a : 16'h3c3c);
      chk(fast_wr_data, 16'h3c3c);
    end
    impl_req = 1'b1;
    mcycle(UWORD_RST);
    chk({15'h0, xfer_addr_vld}, 16'h0000);
    xfer_req = 1'b0;
  endtask

  task automatic sc_implicit;
    for (int i = 0; i < 8; i++) begin
      impl_req = 1'b1;
      impl_out = (i < 4);
      impl_dev = i[1:0];
      ibus_rd = 16'hbe00 + 16'(i);
      w = UWORD_RST;
      w.br_in_sel = BRI_IBUS;
      mcycle(w);
      chk({15'h0, ibus_drive}, {15'h0, impl_out});
      chk({12'h0, dev_load}, impl_out ? (16'h1 << i[1:0]) : 16'h0);
      chk({12'h0, dev_gate}, impl_out ? 16'h0 : (16'h1 << i[1:0]));
      chk({15'h0, br_load}, {15'h0, !impl_out});
      chk(br_in, ibus_rd);
      chk(ibus_wr_data, br_val);
    end
    impl_req = 1'b0;
  endtask

  task automatic sc_buffer;
    sys_bus_rd = 16'h7e7e;
    @(negedge sys_clk);
    t3 = 1'b1;
    @(negedge sys_clk);
    t3 = 1'b0;
    sys_bus_rd = 16'h0101;
    w = UWORD_RST;
    w.br_in_sel = BRI_SYS;
    mcycle(w);
    chk(br_in, 16'h7e7e);
    ce = 1'b0;
    t3 = 1'b1;
    sys_bus_rd = 16'h0f0f;
    @(negedge sys_clk);
    chk(br_in, 16'h7e7e);
    ce = 1'b1;
    sys_bus_rd = 16'h3c5a;
    @(negedge sys_clk);
    t3 = 1'b0;
    chk(br_in, 16'h3c5a);
  endtask

  task automatic sc_console;
    logic [15:0] ed [4];
    load_regs(16'ha1a1, 16'hb2b2, 16'hc3c3);
    ed = '{16'h4342, 16'hc3c3, 16'ha1a1, 16'hb2b2};
    pc_val = 16'h1357;
    @(negedge sys_clk);
    cycle_end = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sw_disp_sel = i[1:0];
      repeat (3) @(negedge sys_clk);
      chk(disp_data, ed[i]);
    end
    chk(disp_addr, 16'h1357);
    sw_addr_hold = 1'b1;
    repeat (2) @(negedge sys_clk);
    pc_val = 16'h2468;
    repeat (2) @(negedge sys_clk);
    chk(disp_addr, 16'h1357);
    sw_addr_hold = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(disp_addr, 16'h2468);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  initial begin
    {rst_b, cycle_start, cycle_end, t3, xfer_req, impl_req, impl_out, sw_addr_hold} = 8'h00;
    {impl_dev, sw_disp_sel} = 4'h0;
    ce = 1'b1;
    uword = UWORD_RST;
    {pc_val, gen_src_rd, gen_dst_rd, exp_val, sys_bus_rd, fast_bus_rd, ibus_rd} = '0;
    trap_vec = 16'h00a4;
    src_const = 16'h0004;
    dst_const = 16'h0008;
    aux_rd = 16'h0000;
    bad_count = 0;
    total_checks = 0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    sc_operands();
    sc_shifter();
    sc_transfer();
    sc_implicit();
    sc_buffer();
    sc_console();
    close_out();
  end
endmodule // tb_top
